// *** serial_unit_pkg.sv ***
`default_nettype none
package serial_unit_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_I2C_CONTROL = 8'hdc;
  localparam logic [7:0] IDX_OWN_ADDRESS = 8'hdd;
  localparam logic [7:0] IDX_UART_SPI_STATUS = 8'he1;
  localparam logic [7:0] IDX_I2C_BUS_STATUS = 8'he2;
  localparam logic [7:0] IDX_DATA_BUFFER = 8'he3;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;

  localparam logic [7:0] I2C_CONTROL_RST = 8'h00;
  localparam logic [7:0] OWN_ADDRESS_RST = 8'h00;
  localparam logic [7:0] UART_SPI_STATUS_RST = 8'h80;
  localparam logic [7:0] I2C_BUS_STATUS_RST = 8'h00;
  localparam logic [7:0] DATA_BUFFER_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // i2c_control_four bit positions
  localparam int CR_IRQ_FLAG = 7;
  localparam int CR_LOGIC_INIT = 5;
  localparam int CR_IRQ_EN = 4;
  localparam int CR_ACK_EN = 3;
  localparam int CR_ROLE = 2;
  localparam int CR_STOP = 1;
  localparam int CR_START = 0;
  // own_address_register: address in [7:1], general call enable in [0]
  localparam int OA_GCE = 0;
  // uart_spi_status positions of software-written bits
  localparam int US_TX_DONE = 6;
  localparam int US_WAKE = 4;
  localparam int US_SOFT_RESET = 3;
  // irq status / mask bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_TX_EMPTY = 2;
  localparam int IRQ_I2C = 3;

  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [3:0] ACK_SLOT = 4'd8;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_HALF_NS = 5000;
  localparam logic [7:0] SCL_HALF_CYCLES =
    8'((SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_complete;
    logic wake;
    logic soft_reset;
    logic overrun;
    logic framing_err;
    logic parity_err;
  } uart_spi_status_t;

  typedef struct packed {
    logic gc_or_address_ack;
    logic byte_done;
    logic stop_seen;
    logic slave_selected;
    logic arb_lost;
    logic bus_busy;
    logic transmitter;
    logic ack_received;
  } i2c_bus_status_t;

  typedef struct packed {
    logic [7:0] data;
    logic framing_err;
    logic parity_err;
  } rx_frame_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } line_events_t;

  typedef enum logic [2:0] {M_IDLE, M_START, M_RUN, M_PREP, M_HIGH} master_state_t;
endpackage
`default_nettype wire

// *** line_sampler.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output serial_unit_pkg::line_events_t ev
);
  import serial_unit_pkg::*;

  logic [1:0] pin_raw;
  logic [1:0] sync_bits;
  logic [1:0] prev_bits;

  assign pin_raw = {scl_in, sda_in};

  genvar i;
  for (i = 0; i < 2; i++) begin : g_sync
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    // idle bus lines are high, so reset to one avoids a false edge
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta_reg <= 1'b1;
        sync_reg <= 1'b1;
        prev_reg <= 1'b1;
      end else begin
        meta_reg <= pin_raw[i];
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
      end
    end
    assign sync_bits[i] = sync_reg;
    assign prev_bits[i] = prev_reg;
  end

  always_comb begin
    ev.scl = sync_bits[1];
    ev.sda = sync_bits[0];
    ev.scl_rise = sync_bits[1] & ~prev_bits[1];
    ev.scl_fall = ~sync_bits[1] & prev_bits[1];
    ev.start = sync_bits[1] & prev_bits[1] & prev_bits[0] & ~sync_bits[0];
    ev.stop = sync_bits[1] & prev_bits[1] & ~prev_bits[0] & sync_bits[0];
  end

  a_rise_after_low: assert property (@(posedge hclk) disable iff (!hresetn)
    ev.scl_rise |-> $past(!ev.scl)) else $error("scl rise without prior low");
  a_start_scl_high: assert property (@(posedge hclk) disable iff (!hresetn)
    ev.start |-> ev.scl && !ev.sda && $past(ev.sda)) else $error("bad start detect");
endmodule
`default_nettype wire

// *** serial_unit_i2c_status_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - ack slot driven low on match, gcall, receiver
// - rx complete while unread data buffered
// - unit soft reset clears unit, self-clears
// - overrun set; frames dropped while set
// - overrun held until data buffer read
// - slave: status bit flags general call
// - master: same bit flags address ack
// - master arbitration lost status bit
// - bus busy zero idle, one busy
// - bus status write clears event bits
// - i2c interrupt holds scl low outside stop mode
// - gcall, byte done, arb lost raise interrupt
// - irq flag set, cleared by status write
// - general call enable accepts general calls
module serial_unit_i2c_status_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic stop_mode,
  input wire logic rx_frame_valid,
  input wire serial_unit_pkg::rx_frame_t rx_frame,
  input wire logic wake_event,
  input wire logic tx_take,
  input wire logic tx_frame_done,
  input wire logic tx_irq_ack,
  output logic [7:0] tx_data,
  output logic i2c_irq,
  output logic irq
);
  import serial_unit_pkg::*;

  line_events_t ev;
  logic acc_valid_reg, acc_write_reg;
  logic [7:0] acc_idx_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] rd_value, wdata;
  logic take, addr_ok, rd_take;
  logic wr_ctrl, wr_own, wr_us, wr_bs, wr_data, wr_mask;
  logic rd_data_buffer, rd_irq_status;
  uart_spi_status_t us_reg;
  i2c_bus_status_t bs_reg;
  logic [7:0] rx_data_reg, tx_data_reg, own_addr_reg;
  logic init_reg, irq_en_reg, ack_en_reg, start_pend_reg, stop_pend_reg;
  logic i2c_irq_flag_reg, i2c_clr, unit_clr, rx_load;
  logic [3:0] irq_st_reg, irq_mask_reg, irq_events;
  logic in_frame_reg, first_byte_reg, addressed_reg, ack_pending_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_shift_reg;
  logic ev_addr_done, ev_byte_done, ev_ack_sample, ev_arb_lost;
  logic addr_match, gcall_hit, gc_set, i2c_event;
  logic role_reg, m_sda_low_reg, m_scl_low_reg, stop_is_reg;
  master_state_t mstate;
  logic [7:0] div_reg;
  logic scl_hold, tick, launch_first, go_prep, clr_start, clr_stop;
  logic sda_tx_low, sda_ack_low;

  line_sampler u_line_sampler (
    .hclk(hclk),
    .hresetn(hresetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // bus slave: zero wait states, read data captured at the address edge
  assign take = hsel & htrans[1] & hready;
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
  assign rd_take = take & ~hwrite & addr_ok;
  assign rd_data_buffer = rd_take && (haddr[9:2] == IDX_DATA_BUFFER);
  assign rd_irq_status = rd_take && (haddr[9:2] == IDX_IRQ_STATUS);
  assign wdata = hwdata[7:0];
  assign wr_ctrl = acc_valid_reg & acc_write_reg & (acc_idx_reg == IDX_I2C_CONTROL);
  assign wr_own = acc_valid_reg & acc_write_reg & (acc_idx_reg == IDX_OWN_ADDRESS);
  assign wr_us = acc_valid_reg & acc_write_reg & (acc_idx_reg == IDX_UART_SPI_STATUS);
  assign wr_bs = acc_valid_reg & acc_write_reg & (acc_idx_reg == IDX_I2C_BUS_STATUS);
  assign wr_data = acc_valid_reg & acc_write_reg & (acc_idx_reg == IDX_DATA_BUFFER);
  assign wr_mask = acc_valid_reg & acc_write_reg & (acc_idx_reg == IDX_IRQ_MASK);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_comb begin
    rd_value = 8'h00;
    if (haddr[9:2] == IDX_I2C_CONTROL) begin
      rd_value = {i2c_irq_flag_reg, 1'b0, init_reg, irq_en_reg, ack_en_reg, role_reg,
                  stop_pend_reg, start_pend_reg};
    end else if (haddr[9:2] == IDX_OWN_ADDRESS) begin
      rd_value = own_addr_reg;
    end else if (haddr[9:2] == IDX_UART_SPI_STATUS) begin
      rd_value = us_reg;
    end else if (haddr[9:2] == IDX_I2C_BUS_STATUS) begin
      rd_value = bs_reg;
    end else if (haddr[9:2] == IDX_DATA_BUFFER) begin
      rd_value = rx_data_reg;
    end else if (haddr[9:2] == IDX_IRQ_STATUS) begin
      rd_value = {4'h0, irq_st_reg};
    end else if (haddr[9:2] == IDX_IRQ_MASK) begin
      rd_value = {4'h0, irq_mask_reg};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_valid_reg <= 1'b0;
      acc_write_reg <= 1'b0;
      acc_idx_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else begin
      acc_valid_reg <= take & addr_ok;
      acc_write_reg <= hwrite;
      acc_idx_reg <= haddr[9:2];
      if (rd_take) begin
        hrdata_reg <= {24'h0, rd_value};
      end
    end
  end

  // control register; the init bit is a one-cycle pulse that reads back as set only during that cycle
  assign i2c_clr = init_reg | us_reg.soft_reset;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {init_reg, irq_en_reg, ack_en_reg} <= I2C_CONTROL_RST[CR_LOGIC_INIT:CR_ACK_EN];
      start_pend_reg <= I2C_CONTROL_RST[CR_START];
      stop_pend_reg <= I2C_CONTROL_RST[CR_STOP];
      own_addr_reg <= OWN_ADDRESS_RST;
    end else begin
      init_reg <= wr_ctrl & wdata[CR_LOGIC_INIT];
      if (i2c_clr) begin
        irq_en_reg <= I2C_CONTROL_RST[CR_IRQ_EN];
        ack_en_reg <= I2C_CONTROL_RST[CR_ACK_EN];
        start_pend_reg <= I2C_CONTROL_RST[CR_START];
        stop_pend_reg <= I2C_CONTROL_RST[CR_STOP];
        own_addr_reg <= OWN_ADDRESS_RST;
      end else begin
        if (wr_ctrl) begin
          irq_en_reg <= wdata[CR_IRQ_EN];
          ack_en_reg <= wdata[CR_ACK_EN];
        end
        // writing zero leaves a pending command in place
        start_pend_reg <= (wr_ctrl & wdata[CR_START]) | (start_pend_reg & ~clr_start);
        stop_pend_reg <= (wr_ctrl & wdata[CR_STOP]) | (stop_pend_reg & ~clr_stop);
        if (wr_own) begin
          own_addr_reg <= wdata;
        end
      end
    end
  end

  // uart/spi status and one-entry receive buffer
  assign unit_clr = us_reg.soft_reset;
  assign rx_load = rx_frame_valid & ~us_reg.overrun & ~(us_reg.rx_complete & ~rd_data_buffer);
  assign tx_data = tx_data_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_reg <= uart_spi_status_t'(UART_SPI_STATUS_RST);
      rx_data_reg <= DATA_BUFFER_RST;
      tx_data_reg <= DATA_BUFFER_RST;
    end else if (unit_clr) begin
      us_reg <= uart_spi_status_t'(UART_SPI_STATUS_RST);
      rx_data_reg <= DATA_BUFFER_RST;
      tx_data_reg <= DATA_BUFFER_RST;
    end else begin
      us_reg.soft_reset <= wr_us & wdata[US_SOFT_RESET];
      if (rx_load) begin
        rx_data_reg <= rx_frame.data;
        us_reg.rx_complete <= 1'b1;
        us_reg.framing_err <= rx_frame.framing_err;
        us_reg.parity_err <= rx_frame.parity_err;
      end else if (rx_frame_valid && !us_reg.overrun) begin
        us_reg.overrun <= 1'b1;
      end else if (rd_data_buffer) begin
        us_reg.rx_complete <= 1'b0;
        us_reg.overrun <= 1'b0;
        us_reg.framing_err <= 1'b0;
        us_reg.parity_err <= 1'b0;
      end
      if (wr_data) begin
        tx_data_reg <= wdata;
        us_reg.tx_empty <= 1'b0;
      end else if (tx_take) begin
        us_reg.tx_empty <= 1'b1;
      end
      if (tx_frame_done) begin
        us_reg.tx_done <= 1'b1;
      end else if (tx_irq_ack || (wr_us && !wdata[US_TX_DONE])) begin
        us_reg.tx_done <= 1'b0;
      end
      if (wake_event) begin
        us_reg.wake <= 1'b1;
      end else if (wr_us && !wdata[US_WAKE]) begin
        us_reg.wake <= 1'b0;
      end
    end
  end

  // byte engine follows the sampled scl whoever drives it
  assign ev_addr_done = in_frame_reg & ev.scl_fall & (bit_cnt_reg == ACK_SLOT - 4'd1);
  assign ev_byte_done = in_frame_reg & ev.scl_fall & (bit_cnt_reg == ACK_SLOT);
  assign ev_ack_sample = in_frame_reg & ev.scl_rise & (bit_cnt_reg == ACK_SLOT);
  assign ev_arb_lost = role_reg & in_frame_reg & (mstate == M_RUN) & ev.scl_rise &
                       (bit_cnt_reg < ACK_SLOT) & bs_reg.transmitter & tx_shift_reg[7] &
                       ~ev.sda;
  assign addr_match = shift_reg[7:1] == own_addr_reg[7:1];
  assign gcall_hit = (shift_reg == GENERAL_CALL_ADDR) & own_addr_reg[OA_GCE];
  // slave event waits for the ninth fall so the scl hold never cuts the ack clock
  assign gc_set = (ev_byte_done & first_byte_reg & ~role_reg & gcall_hit) |
                  (ev_ack_sample & first_byte_reg & role_reg & ~ev.sda);
  assign i2c_event = ev_byte_done | gc_set | ev_arb_lost;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bs_reg <= i2c_bus_status_t'(I2C_BUS_STATUS_RST);
      i2c_irq_flag_reg <= 1'b0;
      in_frame_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      addressed_reg <= 1'b0;
      ack_pending_reg <= 1'b0;
      bit_cnt_reg <= 4'd0;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'hff;
    end else if (i2c_clr) begin
      bs_reg <= i2c_bus_status_t'(I2C_BUS_STATUS_RST);
      i2c_irq_flag_reg <= 1'b0;
      in_frame_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      addressed_reg <= 1'b0;
      ack_pending_reg <= 1'b0;
      bit_cnt_reg <= 4'd0;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'hff;
    end else begin
      // a new event wins over a clearing write in the same cycle
      i2c_irq_flag_reg <= i2c_event | (i2c_irq_flag_reg & ~wr_bs);
      bs_reg.byte_done <= ev_byte_done | (bs_reg.byte_done & ~wr_bs);
      bs_reg.stop_seen <= ev.stop | (bs_reg.stop_seen & ~wr_bs);
      bs_reg.arb_lost <= ev_arb_lost | (bs_reg.arb_lost & ~wr_bs);
      bs_reg.ack_received <= (ev_ack_sample & ~ev.sda) | (bs_reg.ack_received & ~wr_bs);
      bs_reg.slave_selected <= (ev_addr_done & first_byte_reg & ~role_reg &
                                (addr_match | gcall_hit)) | (bs_reg.slave_selected & ~wr_bs);
      if (ev.start) begin
        bs_reg.bus_busy <= 1'b1;
        bs_reg.gc_or_address_ack <= 1'b0;
        bs_reg.transmitter <= role_reg;
        in_frame_reg <= 1'b1;
        first_byte_reg <= 1'b1;
        addressed_reg <= 1'b0;
        ack_pending_reg <= 1'b0;
        // the start's own scl fall wraps this to zero, so it is not counted as a bit
        bit_cnt_reg <= 4'hf;
        tx_shift_reg <= tx_data_reg;
      end else if (ev.stop) begin
        bs_reg.bus_busy <= 1'b0;
        bs_reg.transmitter <= 1'b0;
        in_frame_reg <= 1'b0;
        addressed_reg <= 1'b0;
      end else if (in_frame_reg) begin
        if (gc_set) begin
          bs_reg.gc_or_address_ack <= 1'b1;
        end
        if (ev.scl_rise && bit_cnt_reg < ACK_SLOT) begin
          shift_reg <= {shift_reg[6:0], ev.sda};
        end
        if (ev_addr_done) begin
          if (first_byte_reg && !role_reg) begin
            addressed_reg <= addr_match | gcall_hit;
            ack_pending_reg <= ack_en_reg & (addr_match | gcall_hit);
          end else begin
            ack_pending_reg <= ack_en_reg & ~bs_reg.transmitter & (addressed_reg | role_reg);
          end
        end
        if (ev.scl_fall) begin
          if (bit_cnt_reg == ACK_SLOT) begin
            bit_cnt_reg <= 4'd0;
            first_byte_reg <= 1'b0;
            ack_pending_reg <= 1'b0;
            tx_shift_reg <= tx_data_reg;
            if (first_byte_reg) begin
              bs_reg.transmitter <= role_reg ? ~shift_reg[0] : (addressed_reg & shift_reg[0]);
            end
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            tx_shift_reg <= (bit_cnt_reg == 4'hf) ? tx_shift_reg : {tx_shift_reg[6:0], 1'b1};
          end
        end
      end
    end
  end

  // master sequencer: scl divider plus start, stop and repeated start
  assign scl_hold = i2c_irq_flag_reg & ~stop_mode;
  assign tick = (div_reg == 8'd0) & ~scl_hold;
  assign launch_first = (mstate == M_IDLE) & start_pend_reg & ~bs_reg.bus_busy;
  assign go_prep = (mstate == M_RUN) & tick & m_scl_low_reg & (bit_cnt_reg == 4'd0) &
                   (start_pend_reg | stop_pend_reg);
  assign clr_start = launch_first | (go_prep & ~stop_pend_reg);
  assign clr_stop = go_prep & stop_pend_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mstate <= M_IDLE;
      role_reg <= 1'b0;
      m_sda_low_reg <= 1'b0;
      m_scl_low_reg <= 1'b0;
      stop_is_reg <= 1'b0;
      div_reg <= 8'd0;
    end else if (i2c_clr || ev_arb_lost) begin
      mstate <= M_IDLE;
      role_reg <= 1'b0;
      m_sda_low_reg <= 1'b0;
      m_scl_low_reg <= 1'b0;
      stop_is_reg <= 1'b0;
      div_reg <= 8'd0;
    end else begin
      if (div_reg != 8'd0 && !scl_hold) begin
        div_reg <= div_reg - 8'd1;
      end
      case (mstate)
        M_IDLE: begin
          if (launch_first) begin
            role_reg <= 1'b1;
            m_sda_low_reg <= 1'b1;
            div_reg <= SCL_HALF_CYCLES;
            mstate <= M_START;
          end
        end
        M_START: begin
          if (tick) begin
            m_scl_low_reg <= 1'b1;
            m_sda_low_reg <= 1'b0;
            div_reg <= SCL_HALF_CYCLES;
            mstate <= M_RUN;
          end
        end
        M_RUN: begin
          if (go_prep) begin
            m_sda_low_reg <= stop_pend_reg;
            stop_is_reg <= stop_pend_reg;
            div_reg <= SCL_HALF_CYCLES;
            mstate <= M_PREP;
          end else if (tick) begin
            m_scl_low_reg <= ~m_scl_low_reg;
            div_reg <= SCL_HALF_CYCLES;
          end
        end
        M_PREP: begin
          if (tick) begin
            m_scl_low_reg <= 1'b0;
            div_reg <= SCL_HALF_CYCLES;
            mstate <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (tick) begin
            m_sda_low_reg <= ~stop_is_reg;
            div_reg <= SCL_HALF_CYCLES;
            role_reg <= ~stop_is_reg;
            mstate <= stop_is_reg ? M_IDLE : M_START;
          end
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end

  // open-drain pins: enable low means pulling the line low
  assign sda_tx_low = in_frame_reg & bs_reg.transmitter & (bit_cnt_reg < ACK_SLOT) &
                      ~tx_shift_reg[7] & (~role_reg | (mstate == M_RUN));
  assign sda_ack_low = in_frame_reg & (bit_cnt_reg == ACK_SLOT) & ack_pending_reg;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  // the hold ends when software writes the bus status register
  assign scl_oe_n = ~(m_scl_low_reg | scl_hold);
  assign sda_oe_n = ~(m_sda_low_reg | sda_tx_low | sda_ack_low);
  assign i2c_irq = i2c_irq_flag_reg & irq_en_reg;

  // sticky interrupt status, cleared by reading it; set wins
  always_comb begin
    irq_events = 4'h0;
    irq_events[IRQ_RX] = rx_load;
    irq_events[IRQ_TX_DONE] = tx_frame_done;
    irq_events[IRQ_TX_EMPTY] = tx_take;
    irq_events[IRQ_I2C] = i2c_event & irq_en_reg;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
    end else begin
      irq_st_reg <= (rd_irq_status ? 4'h0 : irq_st_reg) | irq_events;
      if (wr_mask) begin
        irq_mask_reg <= wdata[3:0];
      end
    end
  end
  assign irq = |(irq_st_reg & irq_mask_reg);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_overrun_drops_frame: assert property (
    us_reg.overrun && rx_frame_valid && !rd_data_buffer && !unit_clr |=> $stable(rx_data_reg))
    else $error("frame accepted during overrun");
  a_overrun_read_clear: assert property (
    rd_data_buffer && !rx_frame_valid |=> !us_reg.overrun && !us_reg.rx_complete [*1])
    else $error("read did not clear overrun");
  a_soft_reset_unit: assert property (
    us_reg.soft_reset |=> !us_reg.soft_reset && us_reg.tx_empty && !us_reg.rx_complete)
    else $error("soft reset did not initialise unit");
  a_status_write_clear: assert property (
    wr_bs && !ev_byte_done && !ev.stop |=> !bs_reg.byte_done && !bs_reg.stop_seen)
    else $error("bus status write did not clear");
  a_scl_hold_irq: assert property (
    i2c_irq_flag_reg && !stop_mode |-> !scl_oe_n)
    else $error("scl not held on interrupt");
  a_irq_flag_source: assert property (
    $rose(i2c_irq_flag_reg) |-> $past(ev_byte_done || gc_set || ev_arb_lost))
    else $error("irq flag without source");
  a_ack_drive: assert property (
    ack_pending_reg && in_frame_reg && bit_cnt_reg == ACK_SLOT |-> !sda_oe_n)
    else $error("ack not driven");
  a_busy_after_start: assert property (
    ev.start && !i2c_clr |=> bs_reg.bus_busy ##1 bs_reg.bus_busy || ev.stop || i2c_clr)
    else $error("bus busy not set by start");

  c_byte_done: cover property (ev_byte_done && bs_reg.slave_selected);
  c_arb_lost: cover property (ev_arb_lost);
  c_overrun: cover property (us_reg.overrun && rx_frame_valid);
  c_master_stop: cover property (mstate == M_HIGH && stop_is_reg && tick);
endmodule
`default_nettype wire

// *** i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_rel,
  output logic sda_rel
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // a slave holding scl low stalls us here
  task automatic hi();
    scl_rel = 1'b1;
    wait (scl === 1'b1);
    #400;
  endtask
  task automatic start();
    sda_rel = 1'b0;
    #400;
    scl_rel = 1'b0;
    #200;
  endtask
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_rel = (i == 0) ? 1'b1 : b[i-1];
      #200;
      hi();
      ack = sda;
      scl_rel = 1'b0;
      #200;
    end
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #200;
    hi();
    sda_rel = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// *** serial_unit_i2c_status_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_unit_i2c_status_control_tb_top;
  import serial_unit_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, rxv, ack;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, i2c_irq, irq, m_scl, m_sda;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] txd;
  rx_frame_t rxf;
  int error_cnt, n_tests, cyc;
  // open drain with pull-ups
  wire logic scl = (scl_oe_n | scl_out) & m_scl;
  wire logic sda = (sda_oe_n | sda_out) & m_sda;
  serial_unit_i2c_status_control serial_unit_i2c_status_control_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .stop_mode(1'b0), .rx_frame_valid(rxv),
    .rx_frame(rxf), .wake_event(1'b0), .tx_take(1'b0), .tx_frame_done(1'b0),
    .tx_irq_ack(1'b0), .tx_data(txd), .i2c_irq(i2c_irq), .irq(irq));
  i2c_master_model i2c_master_model_i (.scl(scl), .sda(sda), .scl_rel(m_scl),
    .sda_rel(m_sda));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hsize <= 3'b010;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rx(input logic [7:0] d);
    @(posedge hclk);
    rxv <= 1'b1;
    rxf <= {d, 2'b00};
    @(posedge hclk);
    rxv <= 1'b0;
  endtask
  initial begin
    {hresetn, hsel, htrans, hwrite, rxv, haddr, hwdata, rxf} = '0;
    hsize = 3'b010;
    {error_cnt, n_tests, cyc} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 32'h384, 0);
    chk(rd, 32'h80);
    bus(0, 32'h388, 0);
    chk(rd, 32'h00);
    rx(8'ha5);
    rx(8'h3c);
    rx(8'h11);
    bus(0, 32'h384, 0);
    chk(rd, 32'ha4);
    bus(0, 32'h38c, 0);
    chk(rd, 32'ha5);
    bus(0, 32'h384, 0);
    chk(rd, 32'h80);
    rx(8'h77);
    bus(1, 32'h38c, 32'h5a);
    bus(0, 32'h384, 0);
    chk(rd, 32'h20);
    chk(txd, 32'h5a);
    bus(1, 32'h384, 32'h08);
    bus(0, 32'h384, 0);
    chk(rd, 32'h80);
    chk(txd, 32'h00);
    $display("test receive flags done");
    bus(1, 32'h374, 32'h55);
    bus(1, 32'h370, 32'h18);
    i2c_master_model_i.start();
    i2c_master_model_i.xfer(8'h54, ack);
    repeat (8) @(posedge hclk);
    chk(ack, 0);
    chk({i2c_irq, irq, scl_oe_n}, 3'b100);
    bus(0, 32'h388, 0);
    chk(rd, 32'h55);
    bus(0, 32'h370, 0);
    chk(rd, 32'h98);
    bus(1, 32'h388, 0);
    @(negedge hclk);
    chk(scl_oe_n, 1);
    bus(0, 32'h388, 0);
    chk(rd, 32'h04);
    bus(0, 32'h370, 0);
    chk(rd, 32'h18);
    i2c_master_model_i.stop();
    repeat (8) @(posedge hclk);
    bus(0, 32'h388, 0);
    chk(rd & 32'h24, 32'h20);
    bus(1, 32'h388, 0);
    bus(1, 32'h3c4, 32'h08);
    bus(0, 32'h3c0, 0);
    chk(rd, 32'h09);
    chk(irq, 0);
    i2c_master_model_i.start();
    i2c_master_model_i.xfer(8'h00, ack);
    repeat (8) @(posedge hclk);
    chk({ack, irq}, 2'b01);
    bus(0, 32'h388, 0);
    chk(rd, 32'hd5);
    bus(0, 32'h3c0, 0);
    chk(rd & 32'h08, 32'h08);
    chk(irq, 0);
    bus(1, 32'h388, 0);
    i2c_master_model_i.stop();
    $display("test slave address done");
    bus(1, 32'h370, 32'h38);
    bus(0, 32'h370, 0);
    chk(rd, 0);
    bus(0, 32'h374, 0);
    chk(rd, 0);
    bus(1, 32'h370, 32'h01);
    repeat (5) @(posedge hclk);
    chk(sda_oe_n, 0);
    bus(0, 32'h370, 0);
    chk(rd & 32'h04, 32'h04);
    $display("test init and start done");
    complete_run();
  end
endmodule
`default_nettype wire
